// File: rsac_cfg.svh
// Constants for the RS485 station address and setup register block
`ifndef RSAC_CFG_SVH
`define RSAC_CFG_SVH

// Function codes
`define RSAC_FC_READ_HOLD   8'h03
`define RSAC_FC_READ_INPUT  8'h04
`define RSAC_FC_WRITE_ONE   8'h06

// Write register addresses
`define RSAC_ADDR_STATION   16'h0000
`define RSAC_ADDR_FRAMING   16'h0001

// Read register addresses
`define RSAC_ADDR_SERIAL_LO 16'h0000
`define RSAC_ADDR_SERIAL_HI 16'h0007
`define RSAC_ADDR_FIRMWARE  16'h0008
`define RSAC_ADDR_NAME_LO   16'h0009
`define RSAC_ADDR_NAME_HI   16'h0011

// Address defaults and limits
`define RSAC_ADDR_DEFAULT   8'h43
`define RSAC_MB_ADDR_MIN    8'h01
`define RSAC_MB_ADDR_MAX    8'hF7
`define RSAC_BN_ADDR_MAX    8'h7F
`define RSAC_BN_ZERO_PAT    8'h80
`define RSAC_BN_ADDR_MASK   8'h7F

// Framing word fields
`define RSAC_FRM_BAUD_LSB   0
`define RSAC_FRM_BAUD_MSB   2
`define RSAC_FRM_PAR_LSB    4
`define RSAC_FRM_PAR_MSB    5
`define RSAC_FRM_STOP_BIT   8

// Reset framing: even parity, one stop bit
`define RSAC_PAR_RESET      2'h2
`define RSAC_STOP_RESET     1'b0

// Exception codes
`define RSAC_EXC_FUNC       8'h01
`define RSAC_EXC_ADDR       8'h02
`define RSAC_EXC_VALUE      8'h03

`endif

// File: rsac_pkg.sv
// Types for the RS485 station address and setup register block
package rsac_pkg;

	typedef enum logic [2:0]
	{
		RSAC_BAUD_9600   = 3'h0,
		RSAC_BAUD_19200  = 3'h1,
		RSAC_BAUD_38400  = 3'h2,
		RSAC_BAUD_57600  = 3'h3,
		RSAC_BAUD_76800  = 3'h4,
		RSAC_BAUD_115200 = 3'h5
	} rsac_baud_t;

	typedef enum logic [1:0]
	{
		RSAC_PAR_NONE = 2'h0,
		RSAC_PAR_ODD  = 2'h1,
		RSAC_PAR_EVEN = 2'h2
	} rsac_parity_t;

	typedef enum logic [3:0]
	{
		RSAC_ST_SAMPLE = 4'b0001,
		RSAC_ST_IDLE   = 4'b0010,
		RSAC_ST_READ   = 4'b0100,
		RSAC_ST_DONE   = 4'b1000
	} rsac_state_t;

endpackage

// File: rsac_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`include "rsac_cfg.svh"

module rsac_sync #(
	parameter int WIDTH = 8
)(
	// Clock
	input  wire logic             sys_clk,
	// Pins in, synchronised out
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_q;

	// ********************************************
	// Two stages; first stage feeds only second
	// ********************************************
	// No reset, so the pins settle while the block is held in reset
	always_ff @(posedge sys_clk)
	begin
		meta_q  <= pinIn;
		syncOut <= meta_q;
	end

endmodule // rsac_sync

// File: rsac_regs.sv
// Station address selection and setup/identification holding registers
`timescale 1ns/1ps
`include "rsac_cfg.svh"

module rsac_regs
	import rsac_pkg::*;
#(
	parameter logic [127:0] SERIAL_TEXT = 128'h30303030303030303030303030303031, // arbitrary
	parameter logic [143:0] NAME_TEXT   = {"RS485 SENSOR", 48'h202020202020}, // arbitrary
	parameter logic [7:0]   FW_MAJOR    = 8'h01, // arbitrary
	parameter logic [7:0]   FW_MINOR    = 8'h00, // arbitrary
	parameter logic [2:0]   BAUD_RESET  = 3'h0   // ordered variant
)(
	// Clock and reset
	sys_clk,
	rst,
	// Pins and straps
	addrSwitch,
	bacnetMode,
	// Decoded frame request
	reqValid,
	reqFunc,
	reqAddr,
	reqCount,
	reqData,
	reqReady,
	// Response
	rspValid,
	rspException,
	rspExcCode,
	rspWord,
	rspLast,
	// Active configuration
	stationAddr,
	lineBaud,
	lineParity,
	lineTwoStop
);
	input  wire logic        sys_clk;
	input  wire logic        rst;
	input  wire logic [7:0]  addrSwitch;
	input  wire logic        bacnetMode;
	input  wire logic        reqValid;
	input  wire logic [7:0]  reqFunc;
	input  wire logic [15:0] reqAddr;
	input  wire logic [15:0] reqCount;
	input  wire logic [15:0] reqData;
	output logic             reqReady;
	output logic             rspValid;
	output logic             rspException;
	output logic      [7:0]  rspExcCode;
	output logic      [15:0] rspWord;
	output logic             rspLast;
	output logic      [7:0]  stationAddr;
	output rsac_baud_t       lineBaud;
	output rsac_parity_t     lineParity;
	output logic             lineTwoStop;

	// ********************************************
	// Switch synchroniser and sampling
	// ********************************************
	logic [7:0]  swSync;
	logic [7:0]  swHeld_q;
	rsac_state_t state_q;
	logic [7:0]  storedMb_q;
	logic [7:0]  storedBn_q;
	logic [15:0] rdAddr_q;
	logic [15:0] rdLeft_q;

	rsac_sync #(.WIDTH(8)) uSwSync
	(
		.sys_clk (sys_clk),
		.pinIn   (addrSwitch),
		.syncOut (swSync)
	);

	// Switch value latched once after reset
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			swHeld_q <= 8'h00;
		else if (state_q == RSAC_ST_SAMPLE)
			swHeld_q <= swSync;
	end

	// Latched value is the synchronised switches of the sample cycle
	a_sample_first: assert property (@(posedge sys_clk)
		($rose(state_q == RSAC_ST_IDLE) && $past(state_q) == RSAC_ST_SAMPLE)
		|-> swHeld_q == $past(swSync))
		else $error("switches not sampled before serving");

	// ********************************************
	// Station address selection
	// ********************************************
	always_comb
	begin
		if (bacnetMode)
		begin
			if (swHeld_q == 8'h00)
				stationAddr = storedBn_q;
			else
				stationAddr = swHeld_q & `RSAC_BN_ADDR_MASK;
		end
		else
		begin
			if (swHeld_q == 8'h00)
				stationAddr = storedMb_q;
			else if (swHeld_q > `RSAC_MB_ADDR_MAX)
				stationAddr = storedMb_q;
			else
				stationAddr = swHeld_q;
		end
	end

	// Address selection checks
	a_bn_zero_pattern: assert property (@(posedge sys_clk) disable iff (rst)
		(bacnetMode && swHeld_q == `RSAC_BN_ZERO_PAT) |-> stationAddr == 8'h00)
		else $error("switch pattern 1000 0000 did not give address zero");
	a_stored_address: assert property (@(posedge sys_clk) disable iff (rst)
		(swHeld_q == 8'h00 && !bacnetMode) |-> stationAddr == storedMb_q)
		else $error("stored address not used with switches at zero");
	a_mb_range: assert property (@(posedge sys_clk) disable iff (rst)
		(!bacnetMode && state_q != RSAC_ST_SAMPLE) |->
		(stationAddr >= `RSAC_MB_ADDR_MIN && stationAddr <= `RSAC_MB_ADDR_MAX))
		else $error("modbus address out of range");
	a_bn_range: assert property (@(posedge sys_clk) disable iff (rst)
		bacnetMode |-> stationAddr <= `RSAC_BN_ADDR_MAX)
		else $error("bacnet address out of range");
	a_switch_override: assert property (@(posedge sys_clk) disable iff (rst)
		(!bacnetMode && swHeld_q != 8'h00 && swHeld_q <= `RSAC_MB_ADDR_MAX)
		|-> stationAddr == swHeld_q)
		else $error("switch value did not override stored address");

	// ********************************************
	// Request classification
	// ********************************************
	logic isRead;
	logic isWrite;
	logic [16:0] rdEnd;
	logic rdOk;
	logic wrOk;

	assign isRead = (reqFunc == `RSAC_FC_READ_HOLD) || (reqFunc == `RSAC_FC_READ_INPUT);
	assign isWrite = (reqFunc == `RSAC_FC_WRITE_ONE);
	assign rdEnd = {1'b0, reqAddr} + {1'b0, reqCount};
	assign rdOk = (reqCount != 16'h0000) && (rdEnd <= {1'b0, `RSAC_ADDR_NAME_HI} + 17'h00001);
	assign reqReady = (state_q == RSAC_ST_IDLE);

	always_comb
	begin
		wrOk = 1'b0;
		if (bacnetMode)
			wrOk = 1'b0;
		else if (reqAddr == `RSAC_ADDR_STATION)
			wrOk = (reqData[7:0] >= `RSAC_MB_ADDR_MIN) && (reqData[7:0] <= `RSAC_MB_ADDR_MAX)
				&& (reqData[15:8] == 8'h00);
		else if (reqAddr == `RSAC_ADDR_FRAMING)
			wrOk = (reqData[`RSAC_FRM_BAUD_MSB:`RSAC_FRM_BAUD_LSB] <= 3'h5)
				&& (reqData[`RSAC_FRM_PAR_MSB:`RSAC_FRM_PAR_LSB] != 2'h3);
	end

	// ********************************************
	// Control state machine
	// ********************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_q  <= RSAC_ST_SAMPLE;
			rdAddr_q <= 16'h0000;
			rdLeft_q <= 16'h0000;
		end
		else
		begin
			case (state_q)
				RSAC_ST_SAMPLE:
					state_q <= RSAC_ST_IDLE;
				RSAC_ST_IDLE:
					if (reqValid && isRead && rdOk)
					begin
						rdAddr_q <= reqAddr;
						rdLeft_q <= reqCount;
						state_q  <= RSAC_ST_READ;
					end
					else if (reqValid)
						state_q <= RSAC_ST_DONE;
				RSAC_ST_READ:
				begin
					rdAddr_q <= rdAddr_q + 16'h0001;
					rdLeft_q <= rdLeft_q - 16'h0001;
					if (rdLeft_q == 16'h0001)
						state_q <= RSAC_ST_DONE;
				end
				RSAC_ST_DONE:
					state_q <= RSAC_ST_IDLE;
				default:
					state_q <= RSAC_ST_IDLE;
			endcase
		end
	end

	// ********************************************
	// Stored configuration, written over the bus except storedBn_q, which only reset loads
	// ********************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			storedMb_q  <= `RSAC_ADDR_DEFAULT;
			storedBn_q  <= `RSAC_ADDR_DEFAULT;
			lineBaud    <= rsac_baud_t'(BAUD_RESET);
			lineParity  <= rsac_parity_t'(`RSAC_PAR_RESET);
			lineTwoStop <= `RSAC_STOP_RESET;
		end
		else if (reqReady && reqValid && isWrite && wrOk)
		begin
			if (reqAddr == `RSAC_ADDR_STATION)
				storedMb_q <= reqData[7:0];
			else
			begin
				lineBaud    <= rsac_baud_t'(reqData[`RSAC_FRM_BAUD_MSB:`RSAC_FRM_BAUD_LSB]);
				lineParity  <= rsac_parity_t'(reqData[`RSAC_FRM_PAR_MSB:`RSAC_FRM_PAR_LSB]);
				lineTwoStop <= reqData[`RSAC_FRM_STOP_BIT];
			end
		end
	end

	// Accepted station write lands on the next edge
	a_write_takes: assert property (@(posedge sys_clk) disable iff (rst)
		(reqReady && reqValid && isWrite && wrOk && reqAddr == `RSAC_ADDR_STATION)
		|=> storedMb_q == $past(reqData[7:0]))
		else $error("station address write lost");

	// ********************************************
	// Read data path
	// ********************************************
	logic [15:0] rdWord;
	logic [4:0]  nameIdx;

	assign nameIdx = 5'(rdAddr_q - `RSAC_ADDR_NAME_LO);

	always_comb
	begin
		rdWord = 16'h0000;
		if (rdAddr_q <= `RSAC_ADDR_SERIAL_HI)
			rdWord = SERIAL_TEXT[(7 - rdAddr_q[2:0]) * 16 +: 16];
		else if (rdAddr_q == `RSAC_ADDR_FIRMWARE)
			rdWord = {FW_MAJOR, FW_MINOR};
		else if (rdAddr_q <= `RSAC_ADDR_NAME_HI)
			rdWord = NAME_TEXT[(8 - nameIdx) * 16 +: 16];
	end

	// Response registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rspValid     <= 1'b0;
			rspException <= 1'b0;
			rspExcCode   <= 8'h00;
			rspWord      <= 16'h0000;
			rspLast      <= 1'b0;
		end
		else
		begin
			rspValid     <= 1'b0;
			rspException <= 1'b0;
			rspExcCode   <= 8'h00;
			rspLast      <= 1'b0;
			if (state_q == RSAC_ST_READ)
			begin
				rspValid <= 1'b1;
				rspWord  <= rdWord;
				rspLast  <= (rdLeft_q == 16'h0001);
			end
			else if (reqReady && reqValid && !(isRead && rdOk))
			begin
				rspValid <= 1'b1;
				rspLast  <= 1'b1;
				rspWord  <= reqData;
				if (!isRead && !isWrite)
				begin
					rspException <= 1'b1;
					rspExcCode   <= `RSAC_EXC_FUNC;
				end
				else if (isRead || (reqAddr > `RSAC_ADDR_FRAMING))
				begin
					rspException <= 1'b1;
					rspExcCode   <= `RSAC_EXC_ADDR;
				end
				else if (!wrOk)
				begin
					rspException <= 1'b1;
					rspExcCode   <= `RSAC_EXC_VALUE;
				end
			end
		end
	end

	// Answer word checks
	a_firmware_word: assert property (@(posedge sys_clk) disable iff (rst)
		(state_q == RSAC_ST_READ && rdAddr_q == `RSAC_ADDR_FIRMWARE)
		|=> rspValid && rspWord == {FW_MAJOR, FW_MINOR})
		else $error("firmware word wrong");
	a_read_burst: assert property (@(posedge sys_clk) disable iff (rst)
		(reqReady && reqValid && isRead && rdOk && reqCount == 16'h0001)
		|=> ##1 rspValid && rspLast ##1 !rspValid)
		else $error("single-word read not answered in two cycles");

endmodule // rsac_regs

// File: rsac_master_model.sv
// Bus master model that issues decoded requests and gathers the answers
`timescale 1ns/1ps

module rsac_master_model (
	// Clock
	input  wire logic        sys_clk,
	// Request side
	output logic             reqValid,
	output logic [7:0]       reqFunc,
	output logic [15:0]      reqAddr,
	output logic [15:0]      reqCount,
	output logic [15:0]      reqData,
	input  wire logic        reqReady,
	// Answer side
	input  wire logic        rspValid,
	input  wire logic        rspException,
	input  wire logic [7:0]  rspExcCode,
	input  wire logic [15:0] rspWord,
	input  wire logic        rspLast
);
	logic [15:0] words [$];
	logic        excSeen;
	logic [7:0]  excCode;
	logic        lastSeen;

	// Quiet bus at time zero
	initial
	begin
		reqValid = 1'b0;
		{reqFunc, reqAddr, reqCount, reqData} = '0;
	end

	//****************************************
	// One transfer, optional idle gap first
	//****************************************
	task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c,
		input logic [15:0] d, input int gap);
		int n;
		words = {};
		excSeen = 1'b0;
		lastSeen = 1'b0;
		repeat (gap + 1) @(posedge sys_clk);
		#1;
		reqValid = 1'b1;
		reqFunc = f; // Write 0x06, read 0x03 or 0x04
		reqAddr = a; // Zero-based address
		reqCount = c;
		reqData = d;
		// Hold the request until the edge that takes it
		for (n = 0; n < 40 && reqReady !== 1'b1; n++)
		begin
			@(posedge sys_clk);
			#1;
		end
		@(posedge sys_clk);
		#1;
		// Released lines show the inverse, not the old value
		reqValid = 1'b0;
		reqFunc = ~f;
		reqAddr = ~a;
		reqCount = ~c;
		reqData = ~d;
		for (n = 0; n < 40 && lastSeen !== 1'b1; n++)
		begin
			if (rspValid === 1'b1)
			begin
				words.push_back(rspWord);
				excSeen = rspException;
				excCode = rspExcCode;
				lastSeen = rspLast;
			end
			if (lastSeen !== 1'b1)
			begin
				@(posedge sys_clk);
				#1;
			end
		end
	endtask
endmodule // rsac_master_model

// File: tb_rsac_regs.sv
// Self-checking testbench for the address and setup register block
`timescale 1ns/1ps

`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errTotal++; \
	$display("Error at %0t: got %0h expected %0h", $time, a, b); end end

module tb_rsac_regs
	import rsac_pkg::*;
;
	localparam logic [127:0] SER  = 128'h41423132333435363738394344454647; // arbitrary
	localparam logic [143:0] NAM  = {"TEST STATION", 48'h2A2A2A2A2A2A}; // arbitrary
	localparam logic [7:0]   FMAJ = 8'h02; // arbitrary
	localparam logic [7:0]   FMIN = 8'h07; // arbitrary
	localparam logic [2:0]   BR   = 3'h3;

	logic         sys_clk;
	logic         rst;
	logic [7:0]   addrSwitch;
	logic         bacnetMode;
	logic         reqValid, reqReady, rspValid, rspException, rspLast, lineTwoStop;
	logic [7:0]   reqFunc, rspExcCode, stationAddr, v;
	logic [15:0]  reqAddr, reqCount, reqData, rspWord;
	rsac_baud_t   lineBaud;
	rsac_parity_t lineParity;
	logic [1:0]   p;
	logic [31:0]  seed = 32'hD1B9741A;
	int           errTotal = 0;
	int           samplesChecked = 0;

	rsac_regs #(
		.SERIAL_TEXT (SER),
		.NAME_TEXT   (NAM),
		.FW_MAJOR    (FMAJ),
		.FW_MINOR    (FMIN),
		.BAUD_RESET  (BR)
	) i_dut (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.addrSwitch   (addrSwitch),
		.bacnetMode   (bacnetMode),
		.reqValid     (reqValid),
		.reqFunc      (reqFunc),
		.reqAddr      (reqAddr),
		.reqCount     (reqCount),
		.reqData      (reqData),
		.reqReady     (reqReady),
		.rspValid     (rspValid),
		.rspException (rspException),
		.rspExcCode   (rspExcCode),
		.rspWord      (rspWord),
		.rspLast      (rspLast),
		.stationAddr  (stationAddr),
		.lineBaud     (lineBaud),
		.lineParity   (lineParity),
		.lineTwoStop  (lineTwoStop)
	);
	rsac_master_model i_mst (
		.sys_clk      (sys_clk),
		.reqValid     (reqValid),
		.reqFunc      (reqFunc),
		.reqAddr      (reqAddr),
		.reqCount     (reqCount),
		.reqData      (reqData),
		.reqReady     (reqReady),
		.rspValid     (rspValid),
		.rspException (rspException),
		.rspExcCode   (rspExcCode),
		.rspWord      (rspWord),
		.rspLast      (rspLast)
	);

	// Clock at 25 ns
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected identification word at a wire address
	function automatic logic [15:0] idw(input int a);
		if (a < 8) return SER[127 - 16 * a -: 16];
		if (a == 8) return {FMAJ, FMIN};
		return NAM[143 - 16 * (a - 9) -: 16];
	endfunction

	//****************************************
	// Bench tasks
	//****************************************
	task automatic do_reset(input logic [7:0] sw, input logic bn);
		@(posedge sys_clk);
		#1;
		rst = 1'b1;
		addrSwitch = sw;
		bacnetMode = bn;
		repeat (4) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		// Sample edge, then the first edge with reqReady high
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task automatic rd_item(input logic [7:0] f, input int a, input int c);
		i_mst.xfer(f, 16'(a), 16'(c), 16'(rnd()), int'(rnd() % 3));
		`CHK(i_mst.words.size(), c)
		`CHK(i_mst.excSeen, 1'b0)
		for (int i = 0; i < c && i < i_mst.words.size(); i++)
			`CHK(i_mst.words[i], idw(a + i))
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		i_mst.xfer(8'h06, a, 16'h0000, d, int'(rnd() % 2));
		`CHK({i_mst.excSeen, i_mst.lastSeen, i_mst.words[0]}, {2'b01, d})
	endtask

	task automatic bad(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c,
		input logic [15:0] d, input logic [7:0] code);
		i_mst.xfer(f, a, c, d, 0);
		`CHK({i_mst.excSeen, i_mst.excCode}, {1'b1, code})
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial
	begin
		#(25 * 6000);
		errTotal++;
		tally_and_finish();
	end

	//****************************************
	// Main sequence
	//****************************************
	initial
	begin
		rst = 1'b1;
		addrSwitch = 8'h00;
		bacnetMode = 1'b0;
		do_reset(8'h00, 1'b0);
		`CHK({stationAddr, lineParity, lineTwoStop}, {8'h43, 2'h2, 1'b0})
		`CHK(lineBaud, BR)
		`CHK(reqReady, 1'b1)
		for (int k = 0; k < 2; k++)
		begin
			rd_item(k ? 8'h04 : 8'h03, 0, 8);
			rd_item(k ? 8'h04 : 8'h03, 8, 1);
			rd_item(k ? 8'h04 : 8'h03, 9, 9);
		end
		$display("test identification reads done");
		bad(8'h03, 16'h0012, 16'h0001, 16'h0000, 8'h02);
		bad(8'h04, 16'h0000, 16'h0000, 16'h0000, 8'h02);
		bad(8'h10, 16'h0000, 16'h0001, 16'h0000, 8'h01);
		bad(8'h06, 16'h0002, 16'h0000, 16'h0005, 8'h02);
		bad(8'h06, 16'h0000, 16'h0000, 16'h0000, 8'h03);
		bad(8'h06, 16'h0000, 16'h0000, 16'h00F8, 8'h03);
		bad(8'h06, 16'h0001, 16'h0000, 16'h0006, 8'h03);
		$display("test refusals done");
		for (int i = 0; i < 6; i++)
		begin
			v = (i == 0) ? 8'h01 : (i == 1) ? 8'hF7 : 8'(rnd() % 247) + 8'h01;
			wr(16'h0000, {8'h00, v});
			`CHK(stationAddr, v)
			p = 2'(rnd() % 3);
			wr(16'h0001, {7'h00, v[0], 2'h0, p, 1'b0, 3'(i)});
			`CHK({lineBaud, lineParity, lineTwoStop}, {3'(i), p, v[0]})
		end
		wr(16'h0001, 16'h0020);
		`CHK({lineBaud, lineParity, lineTwoStop}, {RSAC_BAUD_9600, RSAC_PAR_EVEN, 1'b0})
		wr(16'h0001, 16'h0002);
		`CHK({lineBaud, lineParity, lineTwoStop}, {RSAC_BAUD_38400, RSAC_PAR_NONE, 1'b0})
		$display("test setup writes done");
		v = 8'(rnd() % 247) + 8'h01;
		do_reset(v, 1'b0);
		wr(16'h0000, 16'h0005);
		`CHK(stationAddr, v)
		do_reset(8'hF8, 1'b0);
		`CHK(stationAddr, 8'h43)
		do_reset(8'h80, 1'b1);
		`CHK(stationAddr, 8'h00)
		bad(8'h06, 16'h0000, 16'h0000, 16'h0005, 8'h03);
		v = 8'(rnd() % 255) + 8'h01;
		do_reset(v, 1'b1);
		`CHK(stationAddr, v & 8'h7F)
		do_reset(8'h00, 1'b1);
		`CHK(stationAddr, 8'h43)
		$display("test address switches done");
		tally_and_finish();
	end
endmodule // tb_rsac_regs
